// ---- verilog/acsc_regs.svh ----
`ifndef ACSC_REGS_SVH
`define ACSC_REGS_SVH
// Register indices; byte address is four times the index
`define ACSC_CTRL_IDX     8'h3B
`define ACSC_DIAG_IDX     8'h3C
`define ACSC_STAT_IDX     8'h3D
`define ACSC_CTRL_ADDR    8'hEC
`define ACSC_DIAG_ADDR    8'hF0
`define ACSC_STAT_ADDR    8'hF4
// Reset values
`define ACSC_CTRL_RST     16'h0000
`define ACSC_DIAG_RST     16'h0000
// Writable bits of the control register, reserved 7:2 read zero
`define ACSC_CTRL_WMASK   16'hFF03
// Control field positions
`define ACSC_RATE_HI      15
`define ACSC_RATE_LO      14
`define ACSC_MODE_HI      13
`define ACSC_MODE_LO      12
`define ACSC_DEN_HI       11
`define ACSC_DEN_LO       8
`define ACSC_MEN_HI       1
`define ACSC_MEN_LO       0
// Slot 3 source selector position
`define ACSC_SRC3_HI      15
`define ACSC_SRC3_LO      12
// Slot 0 source selector position
`define ACSC_SRC0_HI      3
`define ACSC_SRC0_LO      0
// Status bit positions
`define ACSC_ST_BUSY      0
`define ACSC_ST_DOWN      1
`define ACSC_ST_PWRUP     2
// Power-up wait
`define ACSC_PWRUP_US     100
`define ACSC_CLK_MHZ      200
`define ACSC_PWRUP_CYC    (`ACSC_PWRUP_US * `ACSC_CLK_MHZ)
`endif

// ---- verilog/acsc_pkg.sv ----
`default_nettype none
package acsc_pkg;
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_DOWN  = 5'b00010,
        S_PWRUP = 5'b00100,
        S_ISSUE = 5'b01000,
        S_WAIT  = 5'b10000
    } acsc_state_e;

    // Sequence mode codes
    typedef enum logic [1:0] {
        M_STANDBY = 2'h0,
        M_SINGLE  = 2'h1,
        M_CONT    = 2'h2,
        M_POWDN   = 2'h3
    } acsc_mode_e;

    typedef logic [2:0]  acsc_slot_t;
    typedef logic [15:0] acsc_word_t;

    // Whole state of the sequencer
    typedef struct packed {
        acsc_word_t  ctrl;
        acsc_word_t  diag;
        acsc_state_e state;
        acsc_slot_t  pos;
        logic [15:0] cnt;
        logic        start_pend;
        logic        done_q;
        acsc_word_t  rd_data;
        logic        conv_start;
        acsc_slot_t  conv_slot;
        logic [3:0]  conv_src;
        logic [1:0]  conv_rate;
        logic        busy;
        logic        power;
    } acsc_q_s;
endpackage
`default_nettype wire

// ---- verilog/acsc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for levels from outside the clock domain
module acsc_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;  // First stage, read only by the second
    logic [W-1:0] sync_ff;  // Second stage

    // Both stages clear to zero under reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

// ---- verilog/acsc_slot_pick.sv ----
`timescale 1ns/10ps
`default_nettype none
// Finds the lowest enabled slot at or above a start position
module acsc_slot_pick #(
    parameter int N  = 6,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]  mask,
    input  wire logic [IW-1:0] from,
    output logic               found,
    output logic [IW-1:0]      idx
);
    // Priority scan; a start past the last slot finds nothing
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (mask[i] && (IW'(i) >= from)) begin
                found = 1'b1;
                idx   = IW'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ---- verilog/acsc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "acsc_regs.svh"

module acsc_top #(
    parameter int PWRUP_CYCLES = `ACSC_PWRUP_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic [7:0]          addr,
    input  wire logic [15:0]         wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [15:0]         rd_data_ff,
    input  wire logic                conv_done,
    output logic                     conv_start_ff,
    output acsc_pkg::acsc_slot_t     conv_slot_ff,
    output logic      [3:0]          conv_src_ff,
    output logic      [1:0]          conv_rate_ff,
    output logic                     adc_power_ff,
    output logic                     adc_busy_ff
);
    import acsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State and helpers

    acsc_q_s          q_ff;     // Registered state
    acsc_q_s          nxt_q;    // Next state
    logic             done_s;   // Synchronised conversion done
    logic             done_rise;// One-cycle done event
    logic [5:0]       en_mask;  // Slot enables, measurement slots low
    logic             pk_found; // An enabled slot remains
    acsc_slot_t       pk_idx;   // Next enabled slot
    acsc_mode_e       mode;     // Current sequence mode
    logic [1:0]       rate_raw; // Rate field as written
    logic [1:0]       rate_norm;// Rate after folding undefined code

    // The done level comes from the analogue side, so it is synchronised
    acsc_sync #(
        .W (1)
    ) u_done_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (conv_done),
        .dout    (done_s)
    );

    assign done_rise = done_s && !q_ff.done_q;

    assign en_mask = {q_ff.ctrl[`ACSC_DEN_HI:`ACSC_DEN_LO],
                      q_ff.ctrl[`ACSC_MEN_HI:`ACSC_MEN_LO]};

    assign mode     = acsc_mode_e'(q_ff.ctrl[`ACSC_MODE_HI:`ACSC_MODE_LO]);
    assign rate_raw = q_ff.ctrl[`ACSC_RATE_HI:`ACSC_RATE_LO];

    assign rate_norm = (rate_raw == 2'h3) ? 2'h0 : rate_raw;

    // Walks the enabled slots in ascending order
    acsc_slot_pick #(
        .N  (6),
        .IW (3)
    ) u_pick (
        .mask  (en_mask),
        .from  (q_ff.pos),
        .found (pk_found),
        .idx   (pk_idx)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        nxt_q            = q_ff;
        nxt_q.conv_start = 1'b0;
        nxt_q.rd_data    = 16'h0000;
        nxt_q.done_q     = done_s;

        // Sequencer; runs before the bus so a new request wins over a clear
        case (q_ff.state)
            S_IDLE: begin
                // Powered and waiting for a start
                if (q_ff.start_pend) begin
                    nxt_q.start_pend = 1'b0;
                    nxt_q.busy       = 1'b1;
                    nxt_q.pos        = 3'h0;
                    nxt_q.state      = S_ISSUE;
                end else if (mode == M_POWDN) begin
                    nxt_q.power = 1'b0;
                    nxt_q.state = S_DOWN;
                end
            end
            S_DOWN: begin
                if (q_ff.start_pend) begin
                    nxt_q.start_pend = 1'b0;
                    nxt_q.busy       = 1'b1;
                    nxt_q.power      = 1'b1;
                    nxt_q.cnt        = 16'h0000;
                    nxt_q.state      = S_PWRUP;
                end
            end
            S_PWRUP: begin
                if (q_ff.cnt == 16'(PWRUP_CYCLES - 1)) begin
                    nxt_q.pos   = 3'h0;
                    nxt_q.state = S_ISSUE;
                end else begin
                    nxt_q.cnt = q_ff.cnt + 16'h0001;
                end
            end
            S_ISSUE: begin
                // Issue the next enabled slot, wrap, or close the sequence
                if (pk_found) begin
                    nxt_q.conv_start = 1'b1;
                    nxt_q.conv_slot  = pk_idx;
                    nxt_q.conv_rate  = rate_norm;
                    nxt_q.conv_src   = (pk_idx >= 3'h2)
                        ? 4'(q_ff.diag >> {pk_idx - 3'h2, 2'h0}) : 4'h0;
                    nxt_q.state      = S_WAIT;
                end else if (mode == M_CONT && (|en_mask)) begin
                    nxt_q.pos = 3'h0;
                end else begin
                    nxt_q.busy = 1'b0;
                    if (mode == M_POWDN) begin
                        nxt_q.power = 1'b0;
                        nxt_q.state = S_DOWN;
                    end else begin
                        nxt_q.state = S_IDLE;
                    end
                end
            end
            S_WAIT: begin
                // Converter reports the slot finished
                if (done_rise) begin
                    nxt_q.pos   = q_ff.conv_slot + 3'h1;
                    nxt_q.state = S_ISSUE;
                end
            end
            default: begin
                nxt_q.state = S_IDLE;
            end
        endcase

        // Register writes
        if (wr_en) begin
            case (addr)
                `ACSC_CTRL_ADDR: begin
                    nxt_q.ctrl = wr_data & `ACSC_CTRL_WMASK;
                    // Single or continuous code requests a sequence
                    if (wr_data[`ACSC_MODE_HI:`ACSC_MODE_LO] == M_SINGLE ||
                        wr_data[`ACSC_MODE_HI:`ACSC_MODE_LO] == M_CONT) begin
                        nxt_q.start_pend = 1'b1;
                    end
                end
                `ACSC_DIAG_ADDR: begin
                    nxt_q.diag = wr_data;
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end

        // Register reads; data stand one cycle only
        if (rd_en) begin
            case (addr)
                `ACSC_CTRL_ADDR: nxt_q.rd_data = q_ff.ctrl;
                `ACSC_DIAG_ADDR: nxt_q.rd_data = q_ff.diag;
                `ACSC_STAT_ADDR: begin
                    nxt_q.rd_data[`ACSC_ST_BUSY]  = q_ff.busy;
                    nxt_q.rd_data[`ACSC_ST_DOWN]  = (q_ff.state == S_DOWN);
                    nxt_q.rd_data[`ACSC_ST_PWRUP] = (q_ff.state == S_PWRUP);
                end
                default: nxt_q.rd_data = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // control and source select reset to zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff            <= '0;
            q_ff.ctrl       <= `ACSC_CTRL_RST;
            q_ff.diag       <= `ACSC_DIAG_RST;
            q_ff.state      <= S_IDLE;
            q_ff.power      <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Outputs come straight from the state register
    assign rd_data_ff    = q_ff.rd_data;
    assign conv_start_ff = q_ff.conv_start;
    assign conv_slot_ff  = q_ff.conv_slot;
    assign conv_src_ff   = q_ff.conv_src;
    assign conv_rate_ff  = q_ff.conv_rate;
    assign adc_power_ff  = q_ff.power;
    assign adc_busy_ff   = q_ff.busy;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // All checks run on the one clock and sleep while reset is low
    // Power-up count is a parameter so that tests may shorten it
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_rate_defined: assert property (
        conv_start_ff && $past(rate_raw) != 2'h3 |-> conv_rate_ff == $past(rate_raw))
        else $error("rate code not passed to converter");

    a_rate_fold: assert property (
        conv_start_ff && $past(rate_raw) == 2'h3 |-> conv_rate_ff == 2'h0)
        else $error("undefined rate not folded to 20 SPS");

    a_standby_end: assert property (
        q_ff.state == S_ISSUE && !pk_found && mode == M_STANDBY
        |=> q_ff.state == S_IDLE && adc_power_ff && !adc_busy_ff)
        else $error("standby did not stop powered");

    a_single_end: assert property (
        q_ff.state == S_ISSUE && !pk_found && mode == M_SINGLE
        |=> q_ff.state == S_IDLE ##1 !conv_start_ff)
        else $error("single sequence did not end idle");

    a_cont_wrap: assert property (
        q_ff.state == S_ISSUE && !pk_found && mode == M_CONT && (|en_mask)
        |=> q_ff.state == S_ISSUE && q_ff.pos == 3'h0 && adc_busy_ff)
        else $error("continuous mode did not restart");

    a_pwrup_wait: assert property (
        q_ff.state == S_ISSUE && $past(q_ff.state) == S_PWRUP
        |-> $past(q_ff.cnt) == 16'(PWRUP_CYCLES - 1))
        else $error("power-up delay cut short");

    a_slot_enabled: assert property (
        $rose(conv_start_ff)
        |-> $past(en_mask[pk_idx]) && $past(pk_idx) == conv_slot_ff)
        else $error("disabled slot converted");

    a_meas_src: assert property (
        conv_start_ff && conv_slot_ff < 3'h2 |-> conv_src_ff == 4'h0 && adc_busy_ff)
        else $error("measurement slot source wrong");

    a_slot3_src: assert property (
        conv_start_ff && conv_slot_ff == 3'h5
        |-> conv_src_ff == $past(q_ff.diag[`ACSC_SRC3_HI:`ACSC_SRC3_LO]))
        else $error("slot 3 source not routed");

    a_busy_hold: assert property (
        $fell(adc_busy_ff) |-> (q_ff.state == S_IDLE || q_ff.state == S_DOWN)
        && $past(q_ff.state) == S_ISSUE)
        else $error("busy dropped mid sequence");

    a_down_unpowered: assert property (
        q_ff.state == S_DOWN |-> !adc_power_ff && !adc_busy_ff && !conv_start_ff)
        else $error("converter active while powered down");

    a_idle_powered: assert property (
        q_ff.state == S_IDLE |-> adc_power_ff && !adc_busy_ff)
        else $error("idle converter not powered or still busy");

    a_diag0_src: assert property (
        conv_start_ff && conv_slot_ff == 3'h2
        |-> conv_src_ff == $past(q_ff.diag[`ACSC_SRC0_HI:`ACSC_SRC0_LO]))
        else $error("diagnostic slot 0 source not routed");

    a_busy_start: assert property (
        $rose(adc_busy_ff) |-> $past(q_ff.start_pend) && !conv_start_ff)
        else $error("busy rose without a start request");
endmodule
`default_nettype wire

// ---- verif/test_acsc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "acsc_regs.svh"

module test_acsc_top;
    import acsc_pkg::*;

    localparam int PW = 8;                     // Short power-up wait keeps the run brief

    logic                ref_clk;              // Bench clock, 200 MHz
    logic                rst_n;                // Async reset, active low
    logic [7:0]          addr;                 // Register byte address
    logic [15:0]         wr_data;              // Register write data
    logic                wr_en;                // Write strobe
    logic                rd_en;                // Read strobe
    logic [15:0]         rd_data_ff;           // Read data, cycle after the strobe
    logic                conv_done;            // Converter slot done, driven by bench
    logic                conv_start_ff;        // Start pulse to converter
    acsc_slot_t          conv_slot_ff;         // Slot being converted
    logic [3:0]          conv_src_ff;          // Source code of that slot
    logic [1:0]          conv_rate_ff;         // Folded rate code
    logic                adc_power_ff;         // Converter powered
    logic                adc_busy_ff;          // Sequence active
    int                  err_count = 0;        // Mismatches seen
    int                  n_checks  = 0;        // Comparisons made

    acsc_top #(
        .PWRUP_CYCLES (PW)
    ) dut_u (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .addr          (addr),
        .wr_data       (wr_data),
        .wr_en         (wr_en),
        .rd_en         (rd_en),
        .rd_data_ff    (rd_data_ff),
        .conv_done     (conv_done),
        .conv_start_ff (conv_start_ff),
        .conv_slot_ff  (conv_slot_ff),
        .conv_src_ff   (conv_src_ff),
        .conv_rate_ff  (conv_rate_ff),
        .adc_power_ff  (adc_power_ff),
        .adc_busy_ff   (adc_busy_ff)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock generator
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe; the next access waits for a fresh edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        d = rd_data_ff;
    endtask

    // Host start: wait for idle, quiesce, then program the new request
    task automatic start_seq(input logic [15:0] c);
        logic [15:0] st;
        int          k;
        st = 16'hFFFF;
        for (k = 0; k < 40; k++) begin
            rd(`ACSC_STAT_ADDR, st);
            if (st[`ACSC_ST_BUSY] === 1'b0) break;
        end
        chk("idle_before_start", {15'h0, st[`ACSC_ST_BUSY]}, 16'h0000);
        rd(`ACSC_CTRL_ADDR, st);
        wr(`ACSC_CTRL_ADDR, st & 16'hCFFF);
        wr(`ACSC_CTRL_ADDR, c);
    endtask

    // Waits for one start pulse, judges it, then answers with a done edge
    task automatic conv_cycle(input acsc_slot_t s, input logic [3:0] src,
                              input logic [1:0] rt, output int waited);
        waited = 0;
        while (waited < 1000) begin
            @(negedge ref_clk);
            if (conv_start_ff === 1'b1) break;
            waited++;
        end
        chk("conv_start", {15'h0, conv_start_ff}, 16'h0001);
        chk("conv_slot", {13'h0, conv_slot_ff}, {13'h0, s});
        chk("conv_src", {12'h0, conv_src_ff}, {12'h0, src});
        chk("conv_rate", {14'h0, conv_rate_ff}, {14'h0, rt});
        chk("busy_mid", {15'h0, adc_busy_ff}, 16'h0001);
        @(posedge ref_clk);
        conv_done <= 1'b1;
        @(posedge ref_clk);
        conv_done <= 1'b0;
    endtask

    // Sequence must end without any further start pulse
    task automatic wait_idle();
        logic extra;
        int   k;
        extra = 1'b0;
        for (k = 0; k < 60; k++) begin
            @(negedge ref_clk);
            if (conv_start_ff === 1'b1) extra = 1'b1;
            if (adc_busy_ff === 1'b0) break;
        end
        chk("extra_start", {15'h0, extra}, 16'h0000);
        chk("busy_end", {15'h0, adc_busy_ff}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        logic [15:0] d;
        rd(`ACSC_CTRL_ADDR, d);
        chk("ctrl_reset", d, `ACSC_CTRL_RST);
        rd(`ACSC_DIAG_ADDR, d);
        chk("diag_reset", d, `ACSC_DIAG_RST);
        wr(`ACSC_CTRL_ADDR, 16'hCFFF);
        rd(`ACSC_CTRL_ADDR, d);
        chk("ctrl_reserved", d, 16'hCF03);
        wr(8'h10, 16'hFFFF);
        rd(`ACSC_CTRL_ADDR, d);
        chk("ctrl_after_unmapped", d, 16'hCF03);
        rd(8'h10, d);
        chk("unmapped_read", d, 16'h0000);
        wr(`ACSC_DIAG_ADDR, 16'hF1A5);
        rd(`ACSC_DIAG_ADDR, d);
        chk("diag_rw", d, 16'hF1A5);
        @(negedge ref_clk);
        chk("rd_data_clear", rd_data_ff, 16'h0000);
    endtask

    // Every rate code, the undefined one folding to the slowest rate
    task automatic t_rates();
        int r;
        int w;
        for (r = 0; r < 4; r++) begin
            start_seq({r[1:0], 14'h1002});
            conv_cycle(3'h1, 4'h0, (r == 3) ? 2'b00 : r[1:0], w);
            wait_idle();
        end
    endtask

    // All six slots ascending, each diagnostic with its own source
    task automatic t_all_slots();
        logic [3:0] srcs [6];
        int         k;
        int         w;
        srcs = '{4'h0, 4'h0, 4'h5, 4'hA, 4'h1, 4'hF};
        start_seq(16'h9F03);
        for (k = 0; k < 6; k++) begin
            conv_cycle(k[2:0], srcs[k], 2'b10, w);
        end
        wait_idle();
    endtask

    // No slot enabled: busy pulses for one cycle and no start goes out
    task automatic t_empty();
        start_seq(16'h1000);
        repeat (2) @(negedge ref_clk);
        chk("empty_busy", {15'h0, adc_busy_ff}, 16'h0001);
        wait_idle();
    endtask

    // Continuous wraps; a stop lets the running sequence finish
    task automatic t_cont();
        int w;
        start_seq(16'h2003);
        conv_cycle(3'h0, 4'h0, 2'b00, w);
        conv_cycle(3'h1, 4'h0, 2'b00, w);
        conv_cycle(3'h0, 4'h0, 2'b00, w);
        wr(`ACSC_CTRL_ADDR, 16'h0003);
        conv_cycle(3'h1, 4'h0, 2'b00, w);
        wait_idle();
        chk("power_standby", {15'h0, adc_power_ff}, 16'h0001);
    endtask

    // Power-down, then a start that must first wait out the power-up time
    task automatic t_pdown();
        logic [15:0] d;
        int          w;
        wr(`ACSC_CTRL_ADDR, 16'h3000);
        repeat (4) @(negedge ref_clk);
        chk("power_off", {15'h0, adc_power_ff}, 16'h0000);
        rd(`ACSC_STAT_ADDR, d);
        chk("status_down", d, 16'h0002);
        wr(`ACSC_CTRL_ADDR, 16'h1001);
        // Status read lands inside the power-up wait: busy and wait bits
        rd(`ACSC_STAT_ADDR, d);
        chk("status_pwrup", d, 16'h0005);
        conv_cycle(3'h0, 4'h0, 2'b00, w);
        // The status read above took three cycles out of the wait
        chk("pwrup_wait", {15'h0, (w + 3 >= PW) && (w + 3 <= PW + 10)}, 16'h0001);
        chk("power_on", {15'h0, adc_power_ff}, 16'h0001);
        wait_idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence or the watchdog
    task automatic end_of_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        rst_n     = 1'b0;
        addr      = 8'h00;
        wr_data   = 16'h0000;
        wr_en     = 1'b0;
        rd_en     = 1'b0;
        conv_done = 1'b0;
        // Sample after a clock edge so reset has surely reached the state
        @(negedge ref_clk);
        chk("reset_power", {15'h0, adc_power_ff}, 16'h0001);
        chk("reset_busy", {15'h0, adc_busy_ff}, 16'h0000);
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_rates();
        t_all_slots();
        t_empty();
        t_cont();
        t_pdown();
        end_of_test();
    end
endmodule
`default_nettype wire
